// ---- design/dodi_pkg.sv ----
package dodi_pkg;

    localparam logic [1:0] MODE_REG = 2'h0;
    localparam logic [1:0] MODE_IND = 2'h1;
    localparam logic [1:0] MODE_IDX = 2'h2;
    localparam logic [1:0] MODE_INC = 2'h3;

    localparam logic [2:0] OP3_FMT2 = 3'h1;
    localparam logic [2:0] OP3_CLEAR_BITS = 3'h2;
    localparam logic [2:0] OP3_DIFFERENCE = 3'h3;
    localparam logic [2:0] OP3_COMPARE = 3'h4;
    localparam logic [2:0] OP3_SUM = 3'h5;
    localparam logic [2:0] OP3_COPY = 3'h6;
    localparam logic [2:0] OP3_OR_INTO_DEST = 3'h7;

    localparam logic [5:0] OP6_TEST_ONES = 6'h08;
    localparam logic [5:0] OP6_TEST_ZEROS = 6'h09;
    localparam logic [5:0] OP6_XOR = 6'h0a;
    localparam logic [5:0] OP6_PRODUCT = 6'h0e;
    localparam logic [5:0] OP6_QUOTIENT = 6'h0f;

    // Status bit 0 is the most significant bit of the status word
    localparam int unsigned ST_LGT = 15;
    localparam int unsigned ST_AGT = 14;
    localparam int unsigned ST_EQ = 13;
    localparam int unsigned ST_CARRY = 12;
    localparam int unsigned ST_OVF = 11;
    localparam int unsigned ST_PAR = 10;

    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] ALIGN_MASK = 16'hfffe;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [16:0] ONE_17 = 17'h0_0001;

    typedef struct packed {
        logic [2:0] op3;
        logic byte_flag;
        logic [1:0] dest_mode_field;
        logic [3:0] dreg;
        logic [1:0] source_mode_field;
        logic [3:0] sreg;
    } dodi_instr_s;

    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dodi_mem_req_s;

    typedef struct packed {
        logic ack;
        logic [15:0] rdata;
    } dodi_mem_rsp_s;

    localparam dodi_mem_req_s MEM_IDLE = '0;

    typedef enum logic [3:0] {
        S_IDLE, S_FETCH, S_RESOLVE, S_EXT, S_REGRD, S_ADDR, S_OPRD, S_POST,
        S_INCWR, S_NEXT, S_DREG, S_LORD, S_EXEC, S_WR, S_WR2, S_DONE
    } dodi_state_e;

endpackage : dodi_pkg

// ---- design/dodi_core.sv ----
// Summary of operation
// (RQ1) Format one fields: opcode, byte, modes, registers
// (RQ2) Byte flag picks byte or word operands
// (RQ3) Mode: register, indirect, indexed, auto-increment
// (RQ4) Indexed with register zero means absolute
// (RQ5) Register byte operand is upper byte
// (RQ6) Auto-increment steps one byte, two word
// (RQ7) Source extension word precedes destination one
// (RQ8) Three-bit opcode selects add, compare, subtract...
// (RQ9) Logic and move ops compare result to zero
// (RQ10) Compare writes nothing, sets status bits
// (RQ11) Add and subtract update carry, overflow
// (RQ12) Register-destination format increments by two
// (RQ13) Test-ones sets equal when all covered
// (RQ14) Test-zeros sets equal when none overlap
// (RQ15) Unsigned product into register and next
// (RQ16) Divide overflow when source not above
// (RQ17) Divide stores quotient, remainder in pair
// (RQ18) Format two fields: six-bit opcode first
// (RQ19) Source-only format uses same mode encodings
// (RQ20) Byte compare and copy: source parity
// (RQ21) Add overflow from equal operand signs
module dodi_core (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [15:0] pc_in,
    input wire logic [15:0] wp_in,
    input wire logic [15:0] st_in,
    input wire dodi_pkg::dodi_mem_rsp_s mem_i,
    output dodi_pkg::dodi_mem_req_s mem_o,
    output logic busy,
    output logic done,
    output logic illegal,
    output logic [15:0] pc_out,
    output logic [15:0] st_out,
    output logic [15:0] ea_out
);

    function automatic dodi_pkg::dodi_mem_req_s rd(input logic [15:0] a);
        rd = '{req: 1'b1, we: 1'b0, addr: a, wdata: dodi_pkg::ZERO_WORD};
    endfunction : rd

    function automatic dodi_pkg::dodi_mem_req_s wr(input logic [15:0] a,
                                                   input logic [15:0] d);
        wr = '{req: 1'b1, we: 1'b1, addr: a, wdata: d};
    endfunction : wr

    // Workspace registers sit in memory, two bytes apart from the pointer
    function automatic logic [15:0] reg_addr_of(input logic [15:0] wp,
                                                input logic [3:0] r);
        reg_addr_of = wp + {11'h000, r, 1'b0};
    endfunction : reg_addr_of

    // Even byte address holds the upper byte of a word
    function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic odd);
        pick_byte = odd ? w[7:0] : w[15:8];
    endfunction : pick_byte

    dodi_pkg::dodi_state_e state_reg;
    dodi_pkg::dodi_mem_req_s mem_reg;
    logic busy_reg, done_reg, illegal_reg, phase_reg, sodd_reg;
    logic [15:0] pc_reg, wp_reg, st_reg, ir_reg, base_reg, regval_reg, ea_reg;
    logic [15:0] sval_reg, dval_reg, lo_reg, res2_reg;
    logic [15:0] st_next;

    dodi_pkg::dodi_instr_s f;
    logic [5:0] op6;
    logic is_f1, is_f2, byte_op, idx_used, need_reg, acc;
    logic op6_known, div_ovf, wr_one, wr_two;
    logic [1:0] cur_mode;
    logic [3:0] cur_reg;
    logic [15:0] reg_addr, d_addr, ea_calc, step, s_al, d_al, res, wdata, lo_word;
    logic [16:0] sum17, dif17;
    logic [31:0] prod, quot, rem;

    assign f = dodi_pkg::dodi_instr_s'(ir_reg); // RQ1
    assign op6 = {f.op3, f.byte_flag, f.dest_mode_field}; // RQ18
    assign is_f1 = f.op3 >= dodi_pkg::OP3_CLEAR_BITS;
    assign is_f2 = f.op3 == dodi_pkg::OP3_FMT2;
    assign byte_op = is_f1 & f.byte_flag; // RQ2
    assign op6_known = (op6 == dodi_pkg::OP6_TEST_ONES) | (op6 == dodi_pkg::OP6_TEST_ZEROS)
        | (op6 == dodi_pkg::OP6_XOR) | (op6 == dodi_pkg::OP6_PRODUCT)
        | (op6 == dodi_pkg::OP6_QUOTIENT);

    // Phase 0 resolves the source in every format, phase 1 the format-one destination
    assign cur_mode = phase_reg ? f.dest_mode_field : f.source_mode_field; // RQ3 RQ19
    assign cur_reg = phase_reg ? f.dreg : f.sreg;
    assign reg_addr = reg_addr_of(wp_reg, cur_reg);
    assign d_addr = reg_addr_of(wp_reg, f.dreg);
    assign idx_used = (cur_mode == dodi_pkg::MODE_IDX) && (cur_reg != '0); // RQ4
    assign need_reg = (cur_mode == dodi_pkg::MODE_IND) | (cur_mode == dodi_pkg::MODE_INC)
        | idx_used;
    assign ea_calc = (cur_mode == dodi_pkg::MODE_REG) ? reg_addr
        : (cur_mode == dodi_pkg::MODE_IDX) ? base_reg + (idx_used ? regval_reg
                                                                  : dodi_pkg::ZERO_WORD)
        : regval_reg; // RQ3 RQ4
    // Register-destination and source-only formats never set byte_op
    assign step = byte_op ? dodi_pkg::STEP_BYTE : dodi_pkg::STEP_WORD; // RQ6 RQ12
    assign acc = mem_reg.req & mem_i.ack;

    // Bytes are left-aligned with zero padding so word flags apply unchanged
    assign s_al = byte_op ? {pick_byte(sval_reg, sodd_reg), dodi_pkg::ZERO_BYTE}
                          : sval_reg; // RQ5
    assign d_al = byte_op ? {pick_byte(dval_reg, ea_reg[0]), dodi_pkg::ZERO_BYTE}
                          : dval_reg; // RQ5
    assign sum17 = {1'b0, d_al} + {1'b0, s_al};
    assign dif17 = {1'b0, d_al} + {1'b0, ~s_al} + dodi_pkg::ONE_17; // RQ11
    assign prod = {16'h0000, dval_reg} * {16'h0000, sval_reg}; // RQ15
    assign quot = {dval_reg, lo_reg} / {16'h0000, sval_reg}; // RQ17
    assign rem = {dval_reg, lo_reg} % {16'h0000, sval_reg};
    assign div_ovf = sval_reg <= dval_reg; // RQ16

    always_comb begin
        res = d_al;
        if (is_f2) begin
            res = dval_reg ^ sval_reg;
        end else begin
            unique case (f.op3)
                dodi_pkg::OP3_SUM: res = sum17[15:0];
                dodi_pkg::OP3_DIFFERENCE: res = dif17[15:0];
                dodi_pkg::OP3_OR_INTO_DEST: res = d_al | s_al;
                dodi_pkg::OP3_CLEAR_BITS: res = d_al & ~s_al;
                dodi_pkg::OP3_COPY: res = s_al;
                default: res = d_al;
            endcase // RQ8
        end
    end

    always_comb begin
        st_next = st_reg;
        if (is_f1 && f.op3 == dodi_pkg::OP3_COMPARE) begin
            st_next[dodi_pkg::ST_LGT] = s_al > d_al; // RQ10
            st_next[dodi_pkg::ST_AGT] = $signed(s_al) > $signed(d_al);
            st_next[dodi_pkg::ST_EQ] = s_al == d_al;
            if (byte_op) begin
                st_next[dodi_pkg::ST_PAR] = ^s_al; // RQ20
            end
        end else if (is_f1 || op6 == dodi_pkg::OP6_XOR) begin
            st_next[dodi_pkg::ST_LGT] = res != '0; // RQ9
            st_next[dodi_pkg::ST_AGT] = !res[15] && res != '0;
            st_next[dodi_pkg::ST_EQ] = res == '0;
            if (byte_op) begin
                st_next[dodi_pkg::ST_PAR] = ^res; // RQ9 RQ11 RQ20
            end
            if (is_f1 && f.op3 == dodi_pkg::OP3_SUM) begin
                st_next[dodi_pkg::ST_CARRY] = sum17[16]; // RQ11
                st_next[dodi_pkg::ST_OVF] = (s_al[15] == d_al[15])
                    && (res[15] != d_al[15]); // RQ21
            end
            if (is_f1 && f.op3 == dodi_pkg::OP3_DIFFERENCE) begin
                st_next[dodi_pkg::ST_CARRY] = dif17[16]; // RQ11
                st_next[dodi_pkg::ST_OVF] = (s_al[15] != d_al[15])
                    && (res[15] != d_al[15]);
            end
        end else if (op6 == dodi_pkg::OP6_TEST_ONES) begin
            st_next[dodi_pkg::ST_EQ] = (sval_reg & ~dval_reg) == '0; // RQ13
        end else if (op6 == dodi_pkg::OP6_TEST_ZEROS) begin
            st_next[dodi_pkg::ST_EQ] = (sval_reg & dval_reg) == '0; // RQ14
        end else if (op6 == dodi_pkg::OP6_QUOTIENT) begin
            st_next[dodi_pkg::ST_OVF] = div_ovf; // RQ16
        end
    end

    // Byte writes merge into the destination word read earlier
    assign wdata = !is_f1 ? ((op6 == dodi_pkg::OP6_XOR) ? res
                             : (op6 == dodi_pkg::OP6_PRODUCT) ? prod[31:16]
                             : quot[15:0])
        : !byte_op ? res
        : ea_reg[0] ? {dval_reg[15:8], res[15:8]}
        : {res[15:8], dval_reg[7:0]}; // RQ5
    assign lo_word = (op6 == dodi_pkg::OP6_PRODUCT) ? prod[15:0] : rem[15:0];
    assign wr_one = is_f1 ? (f.op3 != dodi_pkg::OP3_COMPARE) // RQ10
        : (op6 == dodi_pkg::OP6_XOR) | (op6 == dodi_pkg::OP6_PRODUCT)
          | ((op6 == dodi_pkg::OP6_QUOTIENT) & !div_ovf); // RQ16
    assign wr_two = !is_f1 & ((op6 == dodi_pkg::OP6_PRODUCT)
        | ((op6 == dodi_pkg::OP6_QUOTIENT) & !div_ovf));

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg <= dodi_pkg::S_IDLE;
            mem_reg <= dodi_pkg::MEM_IDLE;
            {busy_reg, done_reg, illegal_reg, phase_reg, sodd_reg} <= '0;
            {pc_reg, wp_reg, st_reg, ir_reg, base_reg} <= '0;
            {regval_reg, ea_reg, sval_reg, dval_reg, lo_reg, res2_reg} <= '0;
        end else begin
            done_reg <= 1'b0;
            if (acc) begin
                mem_reg <= dodi_pkg::MEM_IDLE;
            end
            unique case (state_reg)
                dodi_pkg::S_IDLE: begin
                    if (start) begin
                        {pc_reg, wp_reg, st_reg} <= {pc_in, wp_in, st_in};
                        {busy_reg, illegal_reg} <= 2'b10;
                        mem_reg <= rd(pc_in);
                        state_reg <= dodi_pkg::S_FETCH;
                    end
                end
                dodi_pkg::S_FETCH: begin
                    if (acc) begin
                        ir_reg <= mem_i.rdata;
                        pc_reg <= pc_reg + dodi_pkg::STEP_WORD;
                        phase_reg <= 1'b0;
                        state_reg <= dodi_pkg::S_RESOLVE;
                    end
                end
                dodi_pkg::S_RESOLVE: begin
                    if (is_f2 && !op6_known) begin
                        illegal_reg <= 1'b1;
                        state_reg <= dodi_pkg::S_DONE;
                    end else if (cur_mode == dodi_pkg::MODE_IDX) begin
                        mem_reg <= rd(pc_reg); // RQ7
                        state_reg <= dodi_pkg::S_EXT;
                    end else if (need_reg) begin
                        mem_reg <= rd(reg_addr);
                        state_reg <= dodi_pkg::S_REGRD;
                    end else begin
                        state_reg <= dodi_pkg::S_ADDR;
                    end
                end
                dodi_pkg::S_EXT: begin
                    if (acc) begin
                        base_reg <= mem_i.rdata;
                        pc_reg <= pc_reg + dodi_pkg::STEP_WORD;
                        if (idx_used) begin
                            mem_reg <= rd(reg_addr);
                            state_reg <= dodi_pkg::S_REGRD;
                        end else begin
                            state_reg <= dodi_pkg::S_ADDR;
                        end
                    end
                end
                dodi_pkg::S_REGRD: begin
                    if (acc) begin
                        regval_reg <= mem_i.rdata;
                        state_reg <= dodi_pkg::S_ADDR;
                    end
                end
                dodi_pkg::S_ADDR: begin
                    ea_reg <= ea_calc;
                    if (!phase_reg) begin
                        sodd_reg <= ea_calc[0];
                    end
                    // Source-only operands are addressed but not fetched
                    if (is_f1 || is_f2) begin
                        mem_reg <= rd(ea_calc & dodi_pkg::ALIGN_MASK);
                        state_reg <= dodi_pkg::S_OPRD;
                    end else begin
                        state_reg <= dodi_pkg::S_POST;
                    end
                end
                dodi_pkg::S_OPRD: begin
                    if (acc) begin
                        if (phase_reg) begin
                            dval_reg <= mem_i.rdata;
                        end else begin
                            sval_reg <= mem_i.rdata;
                        end
                        state_reg <= dodi_pkg::S_POST;
                    end
                end
                dodi_pkg::S_POST: begin
                    if (cur_mode == dodi_pkg::MODE_INC) begin
                        mem_reg <= wr(reg_addr, regval_reg + step); // RQ6 RQ12
                        state_reg <= dodi_pkg::S_INCWR;
                    end else begin
                        state_reg <= dodi_pkg::S_NEXT;
                    end
                end
                dodi_pkg::S_INCWR: begin
                    if (acc) begin
                        state_reg <= dodi_pkg::S_NEXT;
                    end
                end
                dodi_pkg::S_NEXT: begin
                    if (is_f1 && !phase_reg) begin
                        phase_reg <= 1'b1; // RQ7
                        state_reg <= dodi_pkg::S_RESOLVE;
                    end else if (is_f1) begin
                        state_reg <= dodi_pkg::S_EXEC;
                    end else if (is_f2) begin
                        mem_reg <= rd(d_addr);
                        state_reg <= dodi_pkg::S_DREG;
                    end else begin
                        state_reg <= dodi_pkg::S_DONE; // RQ19
                    end
                end
                dodi_pkg::S_DREG: begin
                    if (acc) begin
                        dval_reg <= mem_i.rdata;
                        if (op6 == dodi_pkg::OP6_QUOTIENT) begin
                            mem_reg <= rd(d_addr + dodi_pkg::STEP_WORD); // RQ17
                            state_reg <= dodi_pkg::S_LORD;
                        end else begin
                            state_reg <= dodi_pkg::S_EXEC;
                        end
                    end
                end
                dodi_pkg::S_LORD: begin
                    if (acc) begin
                        lo_reg <= mem_i.rdata;
                        state_reg <= dodi_pkg::S_EXEC;
                    end
                end
                dodi_pkg::S_EXEC: begin
                    st_reg <= st_next;
                    res2_reg <= lo_word;
                    if (wr_one) begin
                        mem_reg <= wr(is_f1 ? (ea_reg & dodi_pkg::ALIGN_MASK) : d_addr,
                                      wdata);
                        state_reg <= dodi_pkg::S_WR;
                    end else begin
                        state_reg <= dodi_pkg::S_DONE;
                    end
                end
                dodi_pkg::S_WR: begin
                    if (acc) begin
                        if (wr_two) begin
                            // Past the last register this is the next memory word
                            mem_reg <= wr(d_addr + dodi_pkg::STEP_WORD, res2_reg); // RQ15 RQ17
                            state_reg <= dodi_pkg::S_WR2;
                        end else begin
                            state_reg <= dodi_pkg::S_DONE;
                        end
                    end
                end
                dodi_pkg::S_WR2: begin
                    if (acc) begin
                        state_reg <= dodi_pkg::S_DONE;
                    end
                end
                dodi_pkg::S_DONE: begin
                    done_reg <= 1'b1;
                    busy_reg <= 1'b0;
                    state_reg <= dodi_pkg::S_IDLE;
                end
            endcase
        end
    end

    assign mem_o = mem_reg;
    assign busy = busy_reg;
    assign done = done_reg;
    assign illegal = illegal_reg;
    assign pc_out = pc_reg;
    assign st_out = st_reg;
    assign ea_out = ea_reg;

endmodule : dodi_core

// ---- tb/dodi_core_monitor.sv ----
module dodi_core_monitor (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [15:0] pc_in,
    input wire logic [15:0] st_in,
    input wire dodi_pkg::dodi_mem_rsp_s mem_i,
    input wire dodi_pkg::dodi_mem_req_s mem_o,
    input wire logic busy,
    input wire logic done,
    input wire logic [15:0] pc_out,
    input wire logic [15:0] st_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] ir_reg;
    logic [15:0] pc_reg;
    logic [15:0] st_reg;
    logic got_reg;
    logic [1:0] wr_reg;
    wire logic take = start && !busy;
    wire logic [2:0] op3 = ir_reg[15:13];
    wire logic [5:0] op6 = ir_reg[15:10];
    wire logic fmt1 = op3 >= dodi_pkg::OP3_CLEAR_BITS;
    wire logic fmt2 = op3 == dodi_pkg::OP3_FMT2;
    wire logic src_idx = ir_reg[5:4] == dodi_pkg::MODE_IDX;
    wire logic dst_idx = fmt1 && ir_reg[11:10] == dodi_pkg::MODE_IDX;
    wire logic test_op = op6 == dodi_pkg::OP6_TEST_ONES || op6 == dodi_pkg::OP6_TEST_ZEROS;
    wire logic mul_op = op6 == dodi_pkg::OP6_PRODUCT;
    // Divide, whose write count is data-dependent, and XOR are skipped; the test ops and multiply stay in
    wire logic known = fmt1 || !fmt2 || test_op || mul_op;
    wire logic no_inc = ir_reg[5:4] != dodi_pkg::MODE_INC
        && !(fmt1 && ir_reg[11:10] == dodi_pkg::MODE_INC);
    wire logic [1:0] ext_cnt = {1'b0, src_idx} + {1'b0, dst_idx};
    wire logic [1:0] exp_wr = fmt1 ? {1'b0, op3 != dodi_pkg::OP3_COMPARE} : {mul_op, 1'b0};
    wire logic flag_op = op3 inside {dodi_pkg::OP3_OR_INTO_DEST, dodi_pkg::OP3_CLEAR_BITS,
        dodi_pkg::OP3_COPY, dodi_pkg::OP3_COMPARE};
    always_ff @(posedge core_clk) begin
        if (take) begin
            pc_reg <= pc_in;
            st_reg <= st_in;
            got_reg <= 1'b0;
            wr_reg <= 2'h0;
        end else if (mem_o.req && mem_i.ack) begin
            got_reg <= 1'b1;
            ir_reg <= got_reg ? ir_reg : mem_i.rdata;
            wr_reg <= wr_reg + {1'b0, mem_o.we};
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_fetch_first: assert property (take |=> mem_o.req && mem_o.addr == $past(pc_in))
        else $error("fetch not at pc");
    a_req_held: assert property (mem_o.req && !mem_i.ack |=> mem_o.req && $stable(mem_o))
        else $error("request changed before ack");
    a_addr_align: assert property (mem_o.req |-> !mem_o.addr[0])
        else $error("odd bus address");
    a_done_pulse: assert property (done |-> !busy ##1 !done)
        else $error("done not a single pulse");
    a_pc_ext: assert property (done && known |-> pc_out == pc_reg + {13'h0000, ext_cnt, 1'b0}
        + 16'h0002)
        else $error("extension word count wrong");
    a_st_keep: assert property (done && fmt1 |-> st_out[9:0] == st_reg[9:0]
        && (ir_reg[12] || st_out[10] == st_reg[10])) else $error("unrelated status changed");
    a_flag_keep: assert property (done && flag_op |-> st_out[12:11] == st_reg[12:11])
        else $error("carry or overflow changed");
    a_write_count: assert property (done && known && no_inc |-> wr_reg == exp_wr)
        else $error("wrong number of writes");
    a_test_state: assert property (done && test_op
        |-> (st_out & 16'hdfff) == (st_reg & 16'hdfff)) else $error("test op changed status");
endmodule : dodi_core_monitor

bind dodi_core dodi_core_monitor i_dodi_core_monitor (.core_clk(core_clk), .rst_b(rst_b),
    .start(start), .pc_in(pc_in), .st_in(st_in), .mem_i(mem_i), .mem_o(mem_o), .busy(busy),
    .done(done), .pc_out(pc_out), .st_out(st_out));

// ---- tb/dodi_mem_model.sv ----
module dodi_mem_model (
    input wire logic core_clk,
    input wire dodi_pkg::dodi_mem_req_s mem_o,
    input wire logic [1:0] wait_n,
    output wire dodi_pkg::dodi_mem_rsp_s mem_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] words [0:255];
    logic [15:0] last_reg = 16'h0000;
    logic [1:0] cnt_reg = 2'h0;
    wire logic hit = mem_o.req && cnt_reg == wait_n;
    // Idle data is the inverse of the last read, so a late sample never matches by luck
    wire logic [15:0] rd = (hit && !mem_o.we) ? words[mem_o.addr[8:1]] : ~last_reg;
    assign mem_i = {hit, rd};
    always @(posedge core_clk) begin
        cnt_reg <= hit ? 2'h0 : cnt_reg + {1'b0, mem_o.req};
        if (hit && mem_o.we) begin
            words[mem_o.addr[8:1]] <= mem_o.wdata;
        end
        if (hit && !mem_o.we) begin
            last_reg <= rd;
        end
    end
endmodule : dodi_mem_model

// ---- tb/dodi_core_tb.sv ----
module dodi_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk;
    logic rst_b = 1'b0;
    logic start = 1'b0;
    logic [15:0] pc_in = 16'h0100;
    logic [15:0] wp_in = 16'h0020;
    logic [15:0] st_in = 16'h0000;
    logic [1:0] wait_n = 2'h0;
    dodi_pkg::dodi_mem_rsp_s mem_i;
    dodi_pkg::dodi_mem_req_s mem_o;
    logic busy;
    logic done;
    logic illegal;
    logic [15:0] pc_out;
    logic [15:0] st_out;
    logic [15:0] ea_out;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    dodi_core i_dodi_core (.core_clk(core_clk), .rst_b(rst_b), .start(start), .pc_in(pc_in),
        .wp_in(wp_in), .st_in(st_in), .mem_i(mem_i), .mem_o(mem_o), .busy(busy), .done(done),
        .illegal(illegal), .pc_out(pc_out), .st_out(st_out), .ea_out(ea_out));
    dodi_mem_model i_dodi_mem_model (.core_clk(core_clk), .mem_o(mem_o), .wait_n(wait_n),
        .mem_i(mem_i));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic conclude();
        $display("checks=%0d errors=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask : chk
    task automatic put(input logic [7:0] i, input logic [15:0] v);
        i_dodi_mem_model.words[i] = v;
    endtask : put
    function automatic logic [15:0] mw(input logic [7:0] i);
        return i_dodi_mem_model.words[i];
    endfunction : mw
    // Code sits at 0x0100, workspace at 0x0020, operands at 0x0180
    task automatic go(input logic [15:0] ins, x1, x2, st);
        int n;
        n = 0;
        put(8'h80, ins);
        put(8'h81, x1);
        put(8'h82, x2);
        @(negedge core_clk);
        st_in = st;
        start = 1'b1;
        @(negedge core_clk);
        start = 1'b0;
        while (done !== 1'b1 && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        chk({15'h0000, done}, 16'h0001);
    endtask : go
    task automatic rop(input logic [15:0] ins, st, r1, input logic [31:0] d, e,
        input logic [15:0] est);
        put(8'h11, r1);
        put(8'h12, d[31:16]);
        put(8'h13, d[15:0]);
        go(ins, 16'h0000, 16'h0000, st);
        chk(mw(8'h12), e[31:16]);
        chk(mw(8'h13), e[15:0]);
        chk(st_out, est);
        chk(pc_out, 16'h0102);
    endtask : rop
    task automatic s_indexed();
        put(8'h10, 16'h0040);
        put(8'h13, 16'h0180);
        put(8'hc0, 16'h8001);
        put(8'hc1, 16'h5555);
        go(16'hc8e0, 16'h0180, 16'h0002, 16'h000f);
        chk(mw(8'hc1), 16'h8001);
        chk(pc_out, 16'h0106);
        chk(ea_out, 16'h0182);
        chk(st_out, 16'h800f);
    endtask : s_indexed
    task automatic s_autoinc();
        wait_n = 2'h1;
        put(8'h14, 16'h0181);
        put(8'h15, 16'h0184);
        put(8'hc0, 16'h1237);
        put(8'hc2, 16'haaaa);
        go(16'hd574, 16'h0000, 16'h0000, 16'h0000);
        chk(mw(8'hc2), 16'h37aa);
        chk(mw(8'h14), 16'h0182);
        chk(st_out, 16'hc400);
        put(8'h12, 16'h1237);
        put(8'h17, 16'h0180);
        go(16'h20b7, 16'h0000, 16'h0000, 16'h0000);
        chk(mw(8'h17), 16'h0182);
        chk(st_out, 16'h2000);
        put(8'h16, 16'h0180);
        go(16'h0436, 16'h0000, 16'h0000, 16'h5000);
        chk(mw(8'h16), 16'h0182);
        chk(ea_out, 16'h0180);
        chk(st_out, 16'h5000);
        wait_n = 2'h0;
    endtask : s_autoinc
    task automatic s_last_reg();
        put(8'h11, 16'h0002);
        put(8'h1f, 16'h8000);
        put(8'h20, 16'hffff);
        go(16'h3bc1, 16'h0000, 16'h0000, 16'h0000);
        chk(mw(8'h1f), 16'h0001);
        chk(mw(8'h20), 16'h0000);
        put(8'h20, 16'h0003);
        go(16'h3fc1, 16'h0000, 16'h0000, 16'h0000);
        chk(mw(8'h1f), 16'h8001);
        chk(mw(8'h20), 16'h0001);
    endtask : s_last_reg
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        repeat (20) @(negedge core_clk);
        rst_b = 1'b1;
        rop(16'ha081, 16'h0000, 16'h7000, 32'h1000_0000, 32'h8000_0000, 16'h8800);
        rop(16'ha081, 16'h0400, 16'hffff, 32'h0001_0000, 32'h0000_0000, 16'h3400);
        rop(16'h8081, 16'hc000, 16'h0005, 32'h0005_0000, 32'h0005_0000, 16'h2000);
        rop(16'h8081, 16'h0000, 16'hffff, 32'h0001_0000, 32'h0001_0000, 16'h8000);
        rop(16'h6081, 16'h0000, 16'h0001, 32'h0000_0000, 32'hffff_0000, 16'h8000);
        rop(16'he081, 16'h0800, 16'h8000, 32'h0001_0000, 32'h8001_0000, 16'h8800);
        rop(16'h4081, 16'h1000, 16'h00f0, 32'h0fff_0000, 32'h0f0f_0000, 16'hd000);
        rop(16'hc081, 16'hc000, 16'h0000, 32'h1234_0000, 32'h0000_0000, 16'h2000);
        rop(16'hb081, 16'h0000, 16'h7f00, 32'h0100_0000, 32'h8000_0000, 16'h8c00);
        rop(16'h7081, 16'h0000, 16'h0155, 32'h03aa_0000, 32'h02aa_0000, 16'hd400);
        rop(16'h9081, 16'h0000, 16'h0100, 32'h0200_0000, 32'h0200_0000, 16'h0400);
        rop(16'hd081, 16'h0000, 16'h3700, 32'h12ab_0000, 32'h37ab_0000, 16'hc400);
        rop(16'hf081, 16'h0000, 16'h0300, 32'h0455_0000, 32'h0755_0000, 16'hc400);
        rop(16'h5081, 16'h0000, 16'h0100, 32'h0344_0000, 32'h0244_0000, 16'hc400);
        rop(16'h2081, 16'h8000, 16'h0f00, 32'h3f00_0000, 32'h3f00_0000, 16'ha000);
        rop(16'h2081, 16'h2000, 16'h0003, 32'h0001_0000, 32'h0001_0000, 16'h0000);
        rop(16'h2481, 16'h4000, 16'h00f0, 32'hff0f_0000, 32'hff0f_0000, 16'h6000);
        rop(16'h2c81, 16'h1000, 16'h0003, 32'h0005_0006, 32'h0005_0006, 16'h1000);
        chk({15'h0000, illegal}, 16'h0001);
        rop(16'h2881, 16'h0000, 16'h0ff0, 32'h00ff_0000, 32'h0f0f_0000, 16'hc000);
        chk({15'h0000, illegal}, 16'h0000);
        wait_n = 2'h2;
        rop(16'h3881, 16'hf000, 16'h1234, 32'h0100_ffff, 32'h0012_3400, 16'hf000);
        rop(16'h3c81, 16'h0000, 16'h0002, 32'h0002_0007, 32'h0002_0007, 16'h0800);
        rop(16'h3c81, 16'h0800, 16'h0100, 32'h0012_3456, 32'h1234_0056, 16'h0000);
        wait_n = 2'h0;
        s_indexed();
        s_autoinc();
        s_last_reg();
        conclude();
    end
endmodule : dodi_core_tb
